// *** dv/acc_ctrl_tb.sv ***
module acc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // signals
  logic clock, resetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [3:0] pstrb;
  logic [9:0] pos, neg, bg;
  logic [9:0] chan [8];
  logic conv_on, glob, vack, irq, pin_p, pin_n, rd_p, rd_n;
  logic result, capture, pdown, boff_p, boff_n, er;
  logic [2:0] chsel, trig;
  int bad_count, checks, cyc;
  typedef struct {logic [7:0] ctrl; logic [7:0] convb; logic on; logic [2:0] ch;
    logic [9:0] p; logic [9:0] n; logic [9:0] b; logic exp;} acc_row_t;
  // ==========================================================
  // comparator cases: channel k carries level k*64
  acc_row_t rows [10] = '{
    '{8'h00, 8'h00, 1'b0, 3'h0, 10'h200, 10'h100, 10'h000, 1'b1},
    '{8'h00, 8'h00, 1'b0, 3'h0, 10'h100, 10'h100, 10'h000, 1'b0},
    '{8'h40, 8'h00, 1'b0, 3'h0, 10'h000, 10'h100, 10'h300, 1'b1},
    '{8'h40, 8'h00, 1'b0, 3'h0, 10'h3ff, 10'h100, 10'h050, 1'b0},
    '{8'h00, 8'h40, 1'b0, 3'h5, 10'h130, 10'h000, 10'h000, 1'b0},
    '{8'h04, 8'h40, 1'b0, 3'h5, 10'h150, 10'h3ff, 10'h000, 1'b1},
    '{8'h04, 8'h40, 1'b1, 3'h5, 10'h150, 10'h3ff, 10'h000, 1'b0},
    '{8'h00, 8'h40, 1'b0, 3'h0, 10'h001, 10'h3ff, 10'h000, 1'b1},
    '{8'h00, 8'h40, 1'b0, 3'h7, 10'h1bf, 10'h000, 10'h000, 1'b0},
    '{8'h84, 8'h00, 1'b0, 3'h0, 10'h3ff, 10'h000, 10'h000, 1'b0}};
  logic rise_exp [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  logic fall_exp [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

  acc_ctrl acc_ctrl_i (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .positive_input_pin(pos), .negative_input_pin(neg), .bandgap_level(bg), .converter_channel_pins(chan),
    .converter_on(conv_on), .channel_select(chsel), .global_irq_enable(glob), .irq_vector_ack(vack),
    .irq(irq), .positive_port_in(pin_p), .negative_port_in(pin_n), .positive_port_read(rd_p),
    .negative_port_read(rd_n), .cmp_result_bit(result), .capture_input(capture), .cmp_powered_down(pdown),
    .positive_buffer_off(boff_p), .negative_buffer_off(boff_n), .converter_trigger_sel(trig));

  // ==========================================================
  // bus and compare tasks
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
    output logic [31:0] rd, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    pstrb <= s;
    penable <= 1'b0;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] x;
    apb(1'b1, a, d, 4'hf, x, er);
  endtask
  task automatic rdr(input logic [11:0] a, output logic [31:0] v);
    apb(1'b0, a, 8'h00, 4'h0, v, er);
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk8(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop;
    if (bad_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // clock, timeout
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // whole run is well under 3000 cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    {resetn, psel, penable, pwrite, conv_on, glob, vack, pin_p, pin_n} = '0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    {pos, neg, bg, chsel} = '0;
    for (int i = 0; i < 8; i++) chan[i] = 10'(i * 64);
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    foreach (rows[i]) begin
      wr(12'h140, rows[i].ctrl);
      wr(12'h1ec, rows[i].convb);
      conv_on <= rows[i].on;
      chsel <= rows[i].ch;
      pos <= rows[i].p;
      neg <= rows[i].n;
      bg <= rows[i].b;
      waitc(4);
      chk1("result", rows[i].exp, result);
      chk1("capture", rows[i].ctrl[2] & rows[i].exp, capture);
      chk1("powered_down", rows[i].ctrl[7], pdown);
      rdr(12'h140, rv);
      chk8("ctrl_read", {24'h00_0000, rows[i].ctrl | {2'b00, rows[i].exp, 5'h00}}, rv & 32'h0000_00ef);
    end
    // event modes, interrupt enable kept off while the mode changes
    wr(12'h1ec, 8'h00);
    neg <= 10'h100;
    for (int m = 0; m < 4; m++) begin
      pos <= 10'h000;
      wr(12'h140, 8'(m));
      waitc(4);
      wr(12'h200, 8'h01);
      pos <= 10'h200;
      waitc(5);
      rdr(12'h140, rv);
      chk1("flag_rise", rise_exp[m], rv[4]);
      wr(12'h140, 8'(m) | 8'h10);
      pos <= 10'h000;
      waitc(5);
      rdr(12'h140, rv);
      chk1("flag_fall", fall_exp[m], rv[4]);
    end
    // interrupt gating and clearing, rising mode
    glob <= 1'b1;
    wr(12'h140, 8'h0b);
    pos <= 10'h200;
    waitc(6);
    chk1("irq_on", 1'b1, irq);
    glob <= 1'b0;
    waitc(3);
    chk1("irq_global_off", 1'b0, irq);
    glob <= 1'b1;
    wr(12'h204, 8'h00);
    waitc(2);
    chk1("irq_masked", 1'b0, irq);
    wr(12'h204, 8'h01);
    wr(12'h140, 8'h03);
    waitc(2);
    chk1("irq_enable_off", 1'b0, irq);
    wr(12'h140, 8'h0b);
    waitc(2);
    chk1("irq_back", 1'b1, irq);
    vack <= 1'b1;
    @(posedge clock);
    vack <= 1'b0;
    waitc(3);
    chk1("irq_after_vector", 1'b0, irq);
    pos <= 10'h000;
    waitc(4);
    pos <= 10'h200;
    waitc(6);
    wr(12'h200, 8'h00);
    rdr(12'h200, rv);
    chk8("status_kept", 32'h0000_0001, rv);
    wr(12'h140, 8'h1b);
    waitc(2);
    rdr(12'h140, rv);
    chk1("flag_w1c", 1'b0, rv[4]);
    chk1("irq_w1c", 1'b0, irq);
    // input buffers and reserved bits
    pin_p <= 1'b1;
    pin_n <= 1'b1;
    wr(12'h1fc, 8'hff);
    rdr(12'h1fc, rv);
    chk8("buf_read", 32'h0000_0003, rv);
    waitc(2);
    chk1("port_p_off", 1'b0, rd_p);
    chk1("port_n_off", 1'b0, rd_n);
    wr(12'h1fc, 8'h01);
    waitc(2);
    chk1("port_n_on", 1'b1, rd_n);
    chk1("buf_p", 1'b1, boff_p);
    chk1("buf_n", 1'b0, boff_n);
    wr(12'h1ec, 8'hff);
    rdr(12'h1ec, rv);
    chk8("convb_read", 32'h0000_0047, rv);
    chk8("trig", 32'h0000_0007, {29'h0000_0000, trig});
    apb(1'b0, 12'h004, 8'h00, 4'h0, rv, er);
    chk1("unmapped_err", 1'b1, er);
    chk8("unmapped_data", 32'h0000_0000, rv);
    apb(1'b1, 12'h140, 8'h80, 4'h0, rv, er);
    rdr(12'h140, rv);
    chk1("strobe_off", 1'b0, rv[7]);
    // raise the interrupt through the channel mux so that reset has something to drop
    pos <= 10'h000;
    waitc(4);
    pos <= 10'h200;
    waitc(6);
    chk1("irq_pre_reset", 1'b1, irq);
    // reset in mid-run: every register back to its initial value
    resetn <= 1'b0;
    waitc(2);
    chk1("irq_reset", 1'b0, irq);
    resetn <= 1'b1;
    rdr(12'h140, rv);
    chk8("ctrl_reset", 32'h0000_0000, rv & 32'h0000_00df);
    rdr(12'h1ec, rv);
    chk8("convb_reset", 32'h0000_0000, rv);
    rdr(12'h1fc, rv);
    chk8("buf_reset", 32'h0000_0000, rv);
    rdr(12'h204, rv);
    chk8("mask_reset", 32'h0000_0001, rv);
    // result rose from its reset level, which is no real edge
    rdr(12'h140, rv);
    chk1("flag_after_reset", 1'b0, rv[4]);
    report_and_stop();
  end
endmodule

// *** hw/acc_ctrl.sv ***
module acc_ctrl #(
  parameter int VW = 10
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog levels as codes
  input wire logic [VW-1:0] positive_input_pin,
  input wire logic [VW-1:0] negative_input_pin,
  input wire logic [VW-1:0] bandgap_level,
  input wire logic [VW-1:0] converter_channel_pins [8],
  // converter state
  input wire logic converter_on,
  input wire logic [2:0] channel_select,
  // processor side
  input wire logic global_irq_enable,
  input wire logic irq_vector_ack,
  output logic irq,
  // digital port inputs of the two pins
  input wire logic positive_port_in,
  input wire logic negative_port_in,
  output logic positive_port_read,
  output logic negative_port_read,
  // outgoing controls
  output logic cmp_result_bit,
  output logic capture_input,
  output logic cmp_powered_down,
  output logic positive_buffer_off,
  output logic negative_buffer_off,
  output logic [2:0] converter_trigger_sel
);
  // ==========================================================
  // registers
  logic power_off_r;
  logic ref_sel_r;
  logic flag_r;
  logic irq_en_r;
  logic route_r;
  logic [1:0] mode_r;
  logic mux_en_r;
  logic [2:0] trig_sel_r;
  logic [1:0] buf_off_r;
  logic mask_r;
  logic prev_r;
  logic irq_r;
  logic capture_r;
  logic pos_read_r;
  logic neg_read_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;

  // ==========================================================
  // analog input selection and compare
  wire mux_active = mux_en_r & ~converter_on;
  wire [VW-1:0] neg_level = mux_active ? converter_channel_pins[channel_select]
                                       : negative_input_pin;
  wire [VW-1:0] pos_level = ref_sel_r ? bandgap_level : positive_input_pin;
  // powered-down comparator rests low, a power change can fake an edge
  wire raw_cmp = ~power_off_r & (pos_level > neg_level);

  // ==========================================================
  // synchronizer
  wire sync_cmp;

  acc_sync #(
    .STAGES(acc_pkg::SYNC_STAGES)
  ) u_sync (
    .clock(clock),
    .resetn(resetn),
    .d(raw_cmp),
    .q(sync_cmp)
  );

  // ==========================================================
  // edge detection
  // chain and prev_r restart at zero, so a high input would fake an edge after reset
  // limitation: real edges in the first few cycles after reset are not seen
  localparam int SETTLE = acc_pkg::SYNC_STAGES + 1;
  logic [SETTLE-1:0] settle_r;
  wire settled = settle_r[SETTLE-1];
  wire ev_toggle = settled & (sync_cmp ^ prev_r);
  wire ev_fall = settled & prev_r & ~sync_cmp;
  wire ev_rise = settled & sync_cmp & ~prev_r;
  logic event_hit;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      settle_r <= '0;
    end else begin
      settle_r <= {settle_r[SETTLE-2:0], 1'b1};
    end
  end

  always_comb begin
    unique case (mode_r)
      acc_pkg::MODE_TOGGLE: event_hit = ev_toggle;
      acc_pkg::MODE_RSVD: event_hit = 1'b0;
      acc_pkg::MODE_FALL: event_hit = ev_fall;
      acc_pkg::MODE_RISE: event_hit = ev_rise;
    endcase
  end

  // ==========================================================
  // apb decode, one wait state per access
  wire access = psel & penable;
  wire done = access & pready_r;
  wire [9:0] idx = paddr[11:2];
  wire hit_ctrl = idx == acc_pkg::IDX_CTRL;
  wire hit_conv = idx == acc_pkg::IDX_CONV_B;
  wire hit_buf = idx == acc_pkg::IDX_BUF_OFF;
  wire hit_stat = idx == acc_pkg::IDX_IRQ_STAT;
  wire hit_mask = idx == acc_pkg::IDX_IRQ_MASK;
  wire mapped = hit_ctrl | hit_conv | hit_buf | hit_stat | hit_mask;
  wire wr_lane = done & pwrite & pstrb[0];
  wire wr_ctrl = wr_lane & hit_ctrl;
  wire wr_conv = wr_lane & hit_conv;
  wire wr_buf = wr_lane & hit_buf;
  wire wr_stat = wr_lane & hit_stat;
  wire wr_mask = wr_lane & hit_mask;
  wire [7:0] wd = pwdata[7:0];

  // ==========================================================
  // flag: set beats clear
  wire flag_clr = (wr_ctrl & wd[acc_pkg::B_FLAG])
                | (wr_stat & wd[0])
                | irq_vector_ack;
  wire flag_nxt = event_hit | (flag_r & ~flag_clr);

  // ==========================================================
  // read mux
  wire [7:0] rd_ctrl = {power_off_r, ref_sel_r, sync_cmp, flag_r,
                        irq_en_r, route_r, mode_r};
  wire [7:0] rd_conv = {1'b0, mux_en_r, 3'h0, trig_sel_r};
  wire [7:0] rd_buf = {6'h00, buf_off_r};
  wire [7:0] rd_byte = hit_ctrl ? rd_ctrl :
                       hit_conv ? rd_conv :
                       hit_buf ? rd_buf :
                       hit_stat ? {7'h00, flag_r} :
                       hit_mask ? {7'h00, mask_r} : 8'h00;
  wire irq_nxt = flag_r & irq_en_r & global_irq_enable & mask_r;

  // ==========================================================
  // bus response
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= access & ~pready_r;
      pslverr_r <= access & ~pready_r & ~mapped;
      if (access & ~pready_r & ~pwrite) begin
        prdata_r <= {24'h00_0000, rd_byte};
      end
    end
  end

  // ==========================================================
  // control and status register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      power_off_r <= acc_pkg::RST_CTRL[acc_pkg::B_POWER_OFF];
      ref_sel_r <= acc_pkg::RST_CTRL[acc_pkg::B_REF_SEL];
      irq_en_r <= acc_pkg::RST_CTRL[acc_pkg::B_IRQ_EN];
      route_r <= acc_pkg::RST_CTRL[acc_pkg::B_ROUTE];
      mode_r <= acc_pkg::RST_CTRL[acc_pkg::B_MODE_HI:acc_pkg::B_MODE_LO];
    end else if (wr_ctrl) begin
      power_off_r <= wd[acc_pkg::B_POWER_OFF];
      ref_sel_r <= wd[acc_pkg::B_REF_SEL];
      irq_en_r <= wd[acc_pkg::B_IRQ_EN];
      route_r <= wd[acc_pkg::B_ROUTE];
      mode_r <= wd[acc_pkg::B_MODE_HI:acc_pkg::B_MODE_LO];
    end
  end

  // ==========================================================
  // converter control b, buffer disable and mask
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mux_en_r <= acc_pkg::RST_CONV_B[acc_pkg::B_MUX_EN];
      trig_sel_r <= acc_pkg::RST_CONV_B[2:0];
      buf_off_r <= acc_pkg::RST_BUF_OFF;
      mask_r <= acc_pkg::RST_MASK[0];
    end else begin
      if (wr_conv) begin
        mux_en_r <= wd[acc_pkg::B_MUX_EN];
        trig_sel_r <= wd[2:0];
      end
      if (wr_buf) begin
        buf_off_r <= wd[1:0];
      end
      if (wr_mask) begin
        mask_r <= wd[0];
      end
    end
  end

  // ==========================================================
  // event state and registered outputs
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prev_r <= 1'b0;
      flag_r <= acc_pkg::RST_CTRL[acc_pkg::B_FLAG];
      irq_r <= 1'b0;
      capture_r <= 1'b0;
      pos_read_r <= 1'b0;
      neg_read_r <= 1'b0;
    end else begin
      prev_r <= sync_cmp;
      flag_r <= flag_nxt;
      irq_r <= irq_nxt;
      capture_r <= route_r & sync_cmp;
      pos_read_r <= positive_port_in & ~buf_off_r[acc_pkg::B_POS_OFF];
      neg_read_r <= negative_port_in & ~buf_off_r[acc_pkg::B_NEG_OFF];
    end
  end

  // ==========================================================
  // output wiring, all straight from flops
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
  assign cmp_result_bit = sync_cmp;
  assign capture_input = capture_r;
  assign cmp_powered_down = power_off_r;
  assign positive_buffer_off = buf_off_r[acc_pkg::B_POS_OFF];
  assign negative_buffer_off = buf_off_r[acc_pkg::B_NEG_OFF];
  assign positive_port_read = pos_read_r;
  assign negative_port_read = neg_read_r;
  assign converter_trigger_sel = trig_sel_r;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  AST_SYNC_LAT: assert property (
    $past(resetn, 2) |-> cmp_result_bit == $past(raw_cmp, 2))
    else $error("result bit does not follow raw compare by two cycles");

  AST_NEG_SEL: assert property (
    ($past(resetn, 2) && $past(mux_active && !power_off_r, 2))
      |-> cmp_result_bit == $past(pos_level > converter_channel_pins[channel_select], 2))
    else $error("negative input not taken from selected channel");

  AST_POS_SEL: assert property (
    ($past(resetn, 2) && $past(ref_sel_r && !power_off_r, 2))
      |-> cmp_result_bit == $past(bandgap_level > neg_level, 2))
    else $error("positive input not bandgap when reference selected");

  AST_RISE_SET: assert property (
    (settled && mode_r == acc_pkg::MODE_RISE && sync_cmp && !prev_r) |=> flag_r)
    else $error("rising edge did not set event flag");

  AST_FALL_SET: assert property (
    (settled && mode_r == acc_pkg::MODE_FALL && $fell(cmp_result_bit)) |=> flag_r)
    else $error("falling edge did not set event flag");

  AST_RSVD_QUIET: assert property (
    (mode_r == acc_pkg::MODE_RSVD && !flag_r) |=> !flag_r || $past(wr_ctrl))
    else $error("reserved mode set the event flag");

  AST_W1C: assert property (
    (wr_ctrl && wd[acc_pkg::B_FLAG] && !event_hit) |=> !flag_r)
    else $error("write one did not clear event flag");

  AST_VEC_CLR: assert property (
    (irq_vector_ack && !event_hit) |=> !flag_r)
    else $error("vector entry did not clear event flag");

  AST_IRQ: assert property (
    irq == $past(flag_r && irq_en_r && global_irq_enable && mask_r))
    else $error("interrupt output mismatch");

  AST_ROUTE: assert property (
    !route_r ##1 !route_r |-> !capture_input)
    else $error("capture input driven while route disabled");

  AST_BUF_GATE: assert property (
    buf_off_r[acc_pkg::B_POS_OFF] ##1 buf_off_r[acc_pkg::B_POS_OFF] |-> !positive_port_read)
    else $error("disabled positive buffer read as one");

  AST_RSVD_ZERO: assert property (
    (access && !pready_r && !pwrite && hit_buf) |=> prdata[7:2] == 6'h00)
    else $error("buffer disable upper bits not zero");

  AST_POWER: assert property (
    power_off_r [*3] |-> !cmp_result_bit)
    else $error("powered-off comparator shows high result");
endmodule

// *** hw/acc_pkg.sv ***
package acc_pkg;
  // ==========================================================
  // register indices, byte address is four times the index
  localparam logic [9:0] IDX_CTRL = 10'h050;
  localparam logic [9:0] IDX_CONV_B = 10'h07b;
  localparam logic [9:0] IDX_BUF_OFF = 10'h07f;
  localparam logic [9:0] IDX_IRQ_STAT = 10'h080;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h081;
  // ==========================================================
  // control and status, converter control b and buffer disable bit positions
  localparam int B_POWER_OFF = 7;
  localparam int B_REF_SEL = 6;
  localparam int B_RESULT = 5;
  localparam int B_FLAG = 4;
  localparam int B_IRQ_EN = 3;
  localparam int B_ROUTE = 2;
  localparam int B_MODE_HI = 1;
  localparam int B_MODE_LO = 0;
  localparam int B_MUX_EN = 6;
  localparam int B_NEG_OFF = 1;
  localparam int B_POS_OFF = 0;
  // ==========================================================
  // reset values and synchronizer depth
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_CONV_B = 8'h00;
  localparam logic [1:0] RST_BUF_OFF = 2'h0;
  localparam logic [7:0] RST_MASK = 8'h01;
  localparam int SYNC_STAGES = 2;
  // ==========================================================
  // event modes
  localparam logic [1:0] MODE_TOGGLE = 2'h0;
  localparam logic [1:0] MODE_RSVD = 2'h1;
  localparam logic [1:0] MODE_FALL = 2'h2;
  localparam logic [1:0] MODE_RISE = 2'h3;
endpackage

// *** hw/acc_sync.sv ***
module acc_sync #(
  parameter int STAGES = 2
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // level in and out
  input wire logic d,
  output logic q
);
  logic [STAGES-1:0] chain_r;

  // only the last stage is visible outside
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      chain_r <= '0;
    end else begin
      chain_r <= {chain_r[STAGES-2:0], d};
    end
  end

  assign q = chain_r[STAGES-1];
endmodule
